// ---- hdl/can_id_regs_pkg.sv ----
/*
 identifier tag / mask register constants and carriers for the
 message object acceptance block. assumes an 8-bit sfr bus.
*/
package can_id_regs_pkg;
   localparam logic [7:0] tag_byte1_addr  = 8'hbc;
   localparam logic [7:0] tag_byte2_addr  = 8'hbd;
   localparam logic [7:0] tag_byte3_addr  = 8'hbe;
   localparam logic [7:0] tag_byte4_addr  = 8'hbf;
   localparam logic [7:0] mask_byte1_addr = 8'hc4;
   localparam logic [7:0] mask_byte2_addr = 8'hc5;
   localparam logic [7:0] mask_byte3_addr = 8'hc6;
   localparam logic [7:0] mask_byte4_addr = 8'hc7;
   // fourth-byte field positions, byte2 std id position, object count
   localparam int rtr_bit = 2;
   localparam int rb1_bit = 1;
   localparam int rb0_bit = 0;
   localparam int ide_bit = 0;
   localparam int id_lsb_pos = 3;
   localparam int std_id_pos = 5;
   localparam int obj_count = 15;

   typedef struct packed {
      logic [28:0] id;
      logic        rtr;
      logic        ide;
      logic        rb1;
      logic        rb0;
   } frame_hdr_t;

   typedef struct packed {
      logic [28:0] id;
      logic        rtr;
      logic        rb1;
      logic        rb0;
   } tag_t;

   typedef struct packed {
      logic [28:0] id;
      logic        rtr;
      logic        ide;
   } mask_t;
endpackage

// ---- hdl/can_id_tag_mask_regs.sv ----
/*
 identifier tag and mask storage for all message objects, with the
 acceptance compare for the selected object. assumes sfr strobes are
 one-cycle and synchronous to sys_clk; page select comes from the
 controller's paging register.
 limitation: storage has no reset, so the filter result and the
 transmit header are undefined until software has loaded the
 selected object. ext_mode is the layout bit of the selected object
 and is taken from the controller's control logic.
*/
// How it works
// - standard tag byte2: id bits 2..0 at 7..5, low five reserved
// - standard tag byte3 holds no id, all bits reserved
// - standard tag byte4: remote tag bit2, reserved-bit0 tag bit0
// - extended id spread 28-21, 20-13, 12-5, 4-0 at bits 7..3
// - extended tag byte4: remote bit2, rb1 bit1, rb0 bit0
// - standard mask bytes: id 10..3, then id 2..0 at bits 7..5
// - mask one compares the bit, mask zero forces a match
// - reserved bits read back as stored; nothing downstream uses them
// - tag and mask bytes have no reset value
// - mask applies only to reception filtering, never transmit
// - mask byte4: remote mask bit2, extension mask bit0
`timescale 1ns/1ps
module can_id_tag_mask_regs #(
   parameter int objects = can_id_regs_pkg::obj_count
) (
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   // sfr access
   input  wire logic [7:0]                    sfr_addr,
   input  wire logic [7:0]                    sfr_wdata,
   input  wire logic                          sfr_wr,
   input  wire logic                          sfr_rd,
   output logic      [7:0]                    sfr_rdata,
   // object page and layout of the selected object
   input  wire logic [3:0]                    page_sel,
   input  wire logic                          ext_mode,
   // received header to filter
   input  wire logic                          rx_check,
   input  wire can_id_regs_pkg::frame_hdr_t   rx_hdr,
   output logic                               rx_hit,
   output logic                               rx_hit_valid,
   // transmit header of the selected object
   output can_id_regs_pkg::frame_hdr_t        tx_hdr
);
   // page_sel is four bits wide, so at most 16 objects can be paged
   initial
   begin
      if (objects < 1)
         $error("objects must be at least 1");
      if (objects > 16)
         $error("objects must be at most 16");
   end

   // no reset on storage: contents undefined until loaded
   logic [7:0] tag_mem  [objects][4];
   logic [7:0] mask_mem [objects][4];

   // address and page decode
   logic       page_ok;
   logic [1:0] idx;
   logic       is_tag;
   logic       is_mask;

   // widened compare so that a full set of 16 objects still decodes
   assign page_ok = ({1'b0, page_sel} < 5'(objects));
   assign idx     = sfr_addr[1:0];
   assign is_tag  = (sfr_addr[7:2] == can_id_regs_pkg::tag_byte1_addr[7:2]);
   assign is_mask = (sfr_addr[7:2] == can_id_regs_pkg::mask_byte1_addr[7:2]);

   // one write enable per message object
   logic [objects-1:0] obj_wr;

   genvar o;
   generate
      for (o = 0; o < objects; o++)
      begin : g_obj
         // only the paged object sees the strobe
         assign obj_wr[o] = sfr_wr && page_ok && (page_sel == 4'(o));

         // reserved bits stored as written, software keeps them 0
         always_ff @(posedge sys_clk)
         begin
            if (obj_wr[o] && is_tag)
               tag_mem[o][idx] <= sfr_wdata;
            if (obj_wr[o] && is_mask)
               mask_mem[o][idx] <= sfr_wdata;
         end
      end
   endgenerate

   // read mux apart from the register keeps the zero default explicit
   logic [7:0] rd_byte;

   always_comb
   begin
      rd_byte = 8'h00;
      if (page_ok && is_tag)
         rd_byte = tag_mem[page_sel][idx];
      else if (page_ok && is_mask)
         rd_byte = mask_mem[page_sel][idx];
   end

   // reserved positions return whatever was stored
   // holds between reads so software may pick it up late
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         sfr_rdata <= 8'h00;
      else if (sfr_rd)
         sfr_rdata <= rd_byte;
   end

   can_id_regs_pkg::tag_t  tag;
   can_id_regs_pkg::mask_t msk;
   logic [3:0] sel;

   // out-of-range page falls back to object 0 so no read runs off the array
   assign sel = page_ok ? page_sel : 4'h0;

   // tag decode of the selected object
   always_comb
   begin
      tag = '0;
      if (ext_mode)
      begin
         tag.id = {tag_mem[sel][0], tag_mem[sel][1], tag_mem[sel][2],
                   tag_mem[sel][3][7:can_id_regs_pkg::id_lsb_pos]};
         // rb1 tag only in extended layout
         tag.rb1 = tag_mem[sel][3][can_id_regs_pkg::rb1_bit];
      end
      else
      begin
         // std id from bytes 1-2, byte3 ignored
         tag.id[10:0] = {tag_mem[sel][0],
                         tag_mem[sel][1][7:can_id_regs_pkg::std_id_pos]};
      end
      // remote and rb0 tag, common to both layouts
      tag.rtr = tag_mem[sel][3][can_id_regs_pkg::rtr_bit];
      tag.rb0 = tag_mem[sel][3][can_id_regs_pkg::rb0_bit];
   end

   // mask decode of the selected object
   always_comb
   begin
      msk = '0;
      if (ext_mode)
      begin
         msk.id = {mask_mem[sel][0], mask_mem[sel][1], mask_mem[sel][2],
                   mask_mem[sel][3][7:can_id_regs_pkg::id_lsb_pos]};
      end
      else
      begin
         // std mask id bits; upper id bits stay masked off
         msk.id[10:0] = {mask_mem[sel][0],
                         mask_mem[sel][1][7:can_id_regs_pkg::std_id_pos]};
      end
      msk.rtr = mask_mem[sel][3][can_id_regs_pkg::rtr_bit];
      msk.ide = mask_mem[sel][3][can_id_regs_pkg::ide_bit];
   end

   // compared positions: 29 id bits, remote bit, extension bit
   localparam int cmp_bits = 31;

   logic [cmp_bits-1:0] rx_bits;
   logic [cmp_bits-1:0] tag_bits;
   logic [cmp_bits-1:0] msk_bits;
   logic [cmp_bits-1:0] diff;
   logic                match;

   assign rx_bits  = {rx_hdr.id, rx_hdr.rtr, rx_hdr.ide};
   assign tag_bits = {tag.id, tag.rtr, ext_mode};
   assign msk_bits = {msk.id, msk.rtr, msk.ide};

   genvar b;
   generate
      for (b = 0; b < cmp_bits; b++)
      begin : g_cmp
         // mask zero forces this position to match
         assign diff[b] = (rx_bits[b] ^ tag_bits[b]) & msk_bits[b];
      end
   endgenerate

   // all enabled positions agree
   assign match = (diff == '0);

   // result registered; it holds between checks

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_hit       <= 1'b0;
         rx_hit_valid <= 1'b0;
      end
      else
      begin
         rx_hit_valid <= rx_check;
         if (rx_check)
            rx_hit <= match;
      end
   end

   // transmit header built from tag only, mask unused
   // refreshed every cycle, so a store or page change shows a cycle later
   // the extension bit follows the layout, it is not a stored tag
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         tx_hdr <= '0;
      else
      begin
         tx_hdr.id  <= tag.id;
         tx_hdr.rtr <= tag.rtr;
         tx_hdr.ide <= ext_mode;
         tx_hdr.rb1 <= tag.rb1;
         tx_hdr.rb0 <= tag.rb0;
      end
   end
endmodule

// ---- verif/can_id_tag_mask_regs_monitor.sv ----
/* checker for the id tag/mask block.
   bound from tb_top; sees only the block's ports. */
`timescale 1ns/1ps
module can_id_tag_mask_regs_monitor #(
   parameter int objects = 15
) (
   input wire logic       sys_clk, rst, sfr_wr, sfr_rd,
   input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
   input wire logic [3:0] page_sel,
   input wire logic       rx_check, rx_hit, rx_hit_valid,
   input wire can_id_regs_pkg::frame_hdr_t tx_hdr
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence byte4_write;
      sfr_wr && sfr_addr == 8'hbf && page_sel < objects ##1
      !sfr_wr && $stable(page_sel);
   endsequence
   sequence mask_write;
      sfr_wr && sfr_addr[7:2] == 6'h31 ##1 !sfr_wr;
   endsequence
   chk_valid_after_check:
      assert property (rx_check |=> rx_hit_valid) else $error("no valid");
   chk_valid_only_check:
      assert property (!rx_check |=> !rx_hit_valid) else $error("stray");
   chk_hit_holds:
      assert property (!rx_check |=> $stable(rx_hit)) else $error("hit");
   chk_rdata_holds:
      assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("rd");
   chk_unmapped_zero:
      assert property (sfr_rd && !(sfr_addr inside {[8'hbc:8'hbf],
         [8'hc4:8'hc7]}) |=> sfr_rdata == 8'h00) else $error("unmapped");
   chk_page_range:
      assert property (sfr_rd && page_sel >= objects |=> sfr_rdata == 8'h00)
         else $error("page");
   chk_tx_rtr_tag:
      assert property (byte4_write |=> tx_hdr.rtr == $past(sfr_wdata[2], 2))
         else $error("tx rtr");
   chk_mask_no_tx:
      assert property (mask_write |=> $stable(tx_hdr)) else $error("tx");
endmodule

// ---- verif/tb_top.sv ----
/* bench for the id tag/mask block.
   drives sfr and filter ports itself; binds the checker. */
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, rx_check = 0;
   logic ext_mode = 0, rx_hit, rx_hit_valid, e, x;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
   logic [3:0] page_sel = 0;
   logic [31:0] t, m;
   can_id_regs_pkg::frame_hdr_t rx_hdr = 0, tx_hdr, h;
   int miscompares = 0, comparisons = 0;
   // layout, tag bytes, mask bytes, rx id, rtr/ide/rb1/rb0, hit
   // every row leaves the reserved bit positions at zero
   logic [98:0] rows [6] = '{
      {1'b0, 32'hb4600004, 32'hffe00005, 29'h5a3, 4'h8, 1'b1},
      {1'b0, 32'hb4600004, 32'hffc00005, 29'h5a2, 4'h8, 1'b1},
      {1'b1, 32'h091a2b38, 32'hfffffffd, 29'h1234567, 4'h4, 1'b1},
      {1'b1, 32'h091a2b38, 32'hfffffffd, 29'h1234567, 4'hc, 1'b0},
      {1'b1, 32'h091a2b38, 32'hfffffff9, 29'h1234567, 4'hc, 1'b1},
      {1'b1, 32'h091a2b38, 32'hfffffffd, 29'h1234567, 4'h0, 1'b0}};
   can_id_tag_mask_regs i_can_id_tag_mask_regs (.sys_clk(sys_clk),
      .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .page_sel(page_sel), .ext_mode(ext_mode), .rx_check(rx_check),
      .rx_hdr(rx_hdr), .rx_hit(rx_hit), .rx_hit_valid(rx_hit_valid),
      .tx_hdr(tx_hdr));
   initial forever #50 sys_clk = ~sys_clk;
   task chk(logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task wr(logic [7:0] a, d);
      @(posedge sys_clk) {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
      @(posedge sys_clk) sfr_wr <= 0;
   endtask
   task rd(logic [7:0] a, d);
      @(posedge sys_clk) {sfr_addr, sfr_rd} <= {a, 1'b1};
      @(posedge sys_clk) sfr_rd <= 0;
      #1 chk(sfr_rdata, d);
   endtask
   task end_sim;
      $display("compares %0d errors %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #1000000 miscompares++;
      end_sim;
   end
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst <= 0;
      foreach (rows[i])
      begin
         {e, t, m, h, x} = rows[i];
         @(posedge sys_clk) ext_mode <= e;
         for (int k = 0; k < 4; k++) wr(8'hbc + 8'(k), t[31-8*k-:8]);
         for (int k = 0; k < 4; k++) wr(8'hc4 + 8'(k), m[31-8*k-:8]);
         for (int k = 0; k < 4; k++) rd(8'hbc + 8'(k), t[31-8*k-:8]);
         @(posedge sys_clk) {rx_hdr, rx_check} <= {h, 1'b1};
         @(posedge sys_clk) rx_check <= 0;
         #1 chk(rx_hit_valid, 1);
         chk(rx_hit, x);
         chk(tx_hdr.rtr, t[2]);
         chk(tx_hdr.id, e ? t[31:3] : 29'(t[31:21]));
         chk(tx_hdr.ide, e);
         chk(tx_hdr.rb1, e & t[1]);
         chk(tx_hdr.rb0, t[0]);
         $display("row %0d done", i);
      end
      rd(8'hc0, 0);
      @(posedge sys_clk) page_sel <= 4'hf;
      wr(8'hbc, 8'hff);
      rd(8'hbc, 0);
      @(posedge sys_clk) page_sel <= 4'h1;
      wr(8'hbc, 8'h3c);
      rd(8'hbc, 8'h3c);
      @(posedge sys_clk) page_sel <= 4'h0;
      rd(8'hbc, 8'h09);
      $display("paging done");
      @(posedge sys_clk) rst <= 1;
      #1 chk(sfr_rdata, 0);
      chk(rx_hit_valid, 0);
      @(posedge sys_clk) rst <= 0;
      $display("reset done");
      end_sim;
   end
endmodule
bind can_id_tag_mask_regs can_id_tag_mask_regs_monitor #(.objects(objects))
   i_can_id_tag_mask_regs_monitor (.sys_clk(sys_clk), .rst(rst),
   .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .page_sel(page_sel),
   .rx_check(rx_check), .rx_hit(rx_hit), .rx_hit_valid(rx_hit_valid),
   .tx_hdr(tx_hdr));
